// ==== src/let_link_monitor.sv ====
/*
  link monitor: decode fault counting and threshold, open-drain fault
  output with auto clear, self-test mismatch counting, control channel
  enables and holdoff, notify forwarding, two open-drain pins, strap ids.
  assumes decoded control-channel register accesses on clk_sys, and
  fault/lock/link-state inputs from logic on the same clock.
*/
// Contract
// - fault output low when decode count exceeds threshold, normal mode.
// - in self-test, fault output low once any mismatch is counted.
// - fault output released when the decode counter is cleared.
// - reading either counter register clears that counter.
// - auto clear clears decode counter about 1 us after fault goes low.
// - auto clear off after reset; enabled by bit 6 of 0x06.
// - auto clear suppressed while self-test runs.
// - self-test mismatches counted in 8-bit register 0x0E.
// - no decode counting in self-test; fault shows mismatches only.
// - 0x04 bit 1 gates reverse channel, bit 0 gates forward channel.
// - reverse channel held closed for 350 us after each link start or stop.
// - notify input level forwarded on reverse channel, forward link not needed.
// - link-acquired output follows video lock only.
// - pins driven from 0x06 bits 3 and 1, sensed in bits 2 and 0.
// - pin input buffers always on; software sets drive bit for inputs.
// - default ids come from two three-level straps.
// - decode errors counted; bursts halt counter and relock; cleared in self-test.
`timescale 1ns/1ps
module let_link_monitor
  import let_pkg::*;
#(
  parameter int HOLDOFF_CYCLES = HOLDOFF_CYC,
  parameter int BURST_CNT      = BURST_LIMIT,
  parameter int BURST_WIN      = BURST_WINDOW
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // decoded register access
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // link status from the receiver
  input  wire logic       decode_fault_hit,
  input  wire logic       prbs_mismatch_hit,
  input  wire logic       video_lock,
  input  wire logic       serial_link_active,
  output logic            relock_request,
  output logic            link_acquired,
  output logic            pseudo_random_test_enable,
  // control channel gating
  output logic            back_channel_open,
  output logic            ahead_channel_open,
  output logic            notify_to_serializer,
  input  wire logic       remote_notify_in,
  // open-drain fault pin
  output logic            fault_n_out,
  output logic            fault_n_oe,
  // open-drain pins
  input  wire logic       pin0_in,
  output logic            pin0_out,
  output logic            pin0_oe,
  input  wire logic       pin1_in,
  output logic            pin1_out,
  output logic            pin1_oe,
  // three-level straps, both lows mean open
  input  wire logic       device_id_strap_a_hi,
  input  wire logic       device_id_strap_a_lo,
  input  wire logic       device_id_strap_b_hi,
  input  wire logic       device_id_strap_b_lo
);
  // ==========================================================
  // pin synchronisers
  logic [SY_W-1:0] sy_raw;
  logic [SY_W-1:0] sy1_reg;
  logic [SY_W-1:0] sy2_reg;
  logic [SY_W-1:0] sy3_reg;
  logic [SY_W-1:0] sy_val_reg;
  assign sy_raw = {device_id_strap_b_lo, device_id_strap_b_hi, device_id_strap_a_lo,
                   device_id_strap_a_hi, pin1_in, pin0_in, remote_notify_in};
  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (!rstn) begin
          sy1_reg[gi]    <= 1'b0;
          sy2_reg[gi]    <= 1'b0;
          sy3_reg[gi]    <= 1'b0;
          sy_val_reg[gi] <= 1'b0;
        end else begin
          sy1_reg[gi] <= sy_raw[gi];
          sy2_reg[gi] <= sy1_reg[gi];
          sy3_reg[gi] <= sy2_reg[gi];
          // glitch filter: accept only once two stages agree
          if (sy2_reg[gi] == sy3_reg[gi]) begin
            sy_val_reg[gi] <= sy3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // registers
  logic [7:0] ser_id_reg;
  logic [7:0] des_id_reg;
  logic [7:0] link_ctrl_reg;
  logic [7:0] pin_ctrl_reg;
  logic [7:0] thresh_reg;
  logic [7:0] dec_cnt_reg;
  logic [7:0] prbs_cnt_reg;
  logic [1:0] settle_reg;
  logic       strap_done_reg;
  logic       ids_done_reg;
  logic [1:0] code_a;
  logic [1:0] code_b;
  logic       prbs_on;
  logic       auto_en;
  logic       rd_dec;
  logic       rd_prbs;
  assign prbs_on = link_ctrl_reg[BIT_PRBS_EN];
  assign auto_en = pin_ctrl_reg[BIT_AUTO_CLR];
  assign rd_dec  = reg_rd && (reg_addr == ADDR_DEC_CNT);
  assign rd_prbs = reg_rd && (reg_addr == ADDR_PRBS_CNT);
  assign code_a  = sy_val_reg[SY_A_HI] ? STRAP_HIGH :
                   sy_val_reg[SY_A_LO] ? STRAP_LOW : STRAP_OPEN;
  assign code_b  = sy_val_reg[SY_B_HI] ? STRAP_HIGH :
                   sy_val_reg[SY_B_LO] ? STRAP_LOW : STRAP_OPEN;

  // straps caught once the synchronisers have settled after release
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      settle_reg     <= 2'h0;
      strap_done_reg <= 1'b0;
    end else if (settle_reg != STRAP_SETTLE) begin
      settle_reg <= settle_reg + 2'h1;
    end else begin
      strap_done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ser_id_reg   <= 8'h00;
      des_id_reg   <= 8'h00;
      ids_done_reg <= 1'b0;
    end else if (!ids_done_reg) begin
      // filtered straps land on the edge that sets strap_done, so load one later
      if (strap_done_reg) begin
        ser_id_reg   <= {code_a, SER_ID_MID, code_b, 2'h0};
        des_id_reg   <= {code_a, DES_ID_MID, code_b, 2'h0};
        ids_done_reg <= 1'b1;
      end
    end else if (reg_wr && reg_addr == ADDR_SER_ID) begin
      ser_id_reg <= {reg_wdata[7:1], 1'b0};
    end else if (reg_wr && reg_addr == ADDR_DES_ID) begin
      des_id_reg <= {reg_wdata[7:1], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      link_ctrl_reg <= RST_LINK_CTRL;
      pin_ctrl_reg  <= RST_PIN_CTRL;
      thresh_reg    <= RST_THRESH;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_LINK_CTRL) link_ctrl_reg <= reg_wdata;
      if (reg_addr == ADDR_PIN_CTRL)  pin_ctrl_reg  <= reg_wdata;
      if (reg_addr == ADDR_THRESH)    thresh_reg    <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_SER_ID:    reg_rdata <= ser_id_reg;
        ADDR_DES_ID:    reg_rdata <= des_id_reg;
        ADDR_LINK_CTRL: reg_rdata <= link_ctrl_reg;
        ADDR_PIN_CTRL:  reg_rdata <= {pin_ctrl_reg[7:4], pin_ctrl_reg[BIT_PIN1_DRV],
                                      sy_val_reg[SY_PIN1], pin_ctrl_reg[BIT_PIN0_DRV],
                                      sy_val_reg[SY_PIN0]};
        ADDR_THRESH:    reg_rdata <= thresh_reg;
        ADDR_DEC_CNT:   reg_rdata <= dec_cnt_reg;
        ADDR_PRBS_CNT:  reg_rdata <= prbs_cnt_reg;
        default:        reg_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // decode fault counting
  logic        lock_q_reg;
  logic        lock_rise;
  logic        halt_reg;
  logic [15:0] win_reg;
  logic [15:0] burst_reg;
  logic [7:0]  auto_tmr_reg;
  logic        auto_fire;
  logic        dec_clr;
  assign lock_rise = video_lock && !lock_q_reg;
  assign auto_fire = auto_en && !prbs_on && fault_n_oe &&
                     (auto_tmr_reg == 8'(AUTO_CLR_CYC - 1));
  assign dec_clr   = rd_dec || lock_rise || auto_fire;

  // burst guard: many faults inside one window stop the counter
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lock_q_reg     <= 1'b0;
      halt_reg       <= 1'b0;
      win_reg        <= 16'h0000;
      burst_reg      <= 16'h0000;
      relock_request <= 1'b0;
    end else begin
      lock_q_reg     <= video_lock;
      relock_request <= 1'b0;
      if (win_reg == 16'(BURST_WIN - 1)) begin
        win_reg   <= 16'h0000;
        burst_reg <= 16'h0000;
      end else begin
        win_reg <= win_reg + 16'h0001;
        if (decode_fault_hit && !prbs_on) burst_reg <= burst_reg + 16'h0001;
      end
      if (lock_rise) begin
        halt_reg <= 1'b0;
      end else if (!halt_reg && burst_reg >= 16'(BURST_CNT)) begin
        halt_reg       <= 1'b1;
        relock_request <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dec_cnt_reg <= 8'h00;
    end else if (prbs_on) begin
      dec_cnt_reg <= 8'h00;
    end else if (decode_fault_hit && !halt_reg) begin
      // a fault in the clearing cycle survives as the first count
      if (dec_clr) dec_cnt_reg <= 8'h01;
      else if (dec_cnt_reg != CNT_MAX) dec_cnt_reg <= dec_cnt_reg + 8'h01;
    end else if (dec_clr) begin
      dec_cnt_reg <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      prbs_cnt_reg <= 8'h00;
    end else if (prbs_on && prbs_mismatch_hit) begin
      if (rd_prbs) prbs_cnt_reg <= 8'h01;
      else if (prbs_cnt_reg != CNT_MAX) prbs_cnt_reg <= prbs_cnt_reg + 8'h01;
    end else if (rd_prbs) begin
      prbs_cnt_reg <= 8'h00;
    end
  end

  // ==========================================================
  // fault pin and auto clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      auto_tmr_reg <= 8'h00;
    end else if (auto_en && !prbs_on && fault_n_oe && !auto_fire) begin
      auto_tmr_reg <= auto_tmr_reg + 8'h01;
    end else begin
      auto_tmr_reg <= 8'h00;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fault_n_out <= 1'b0;
      fault_n_oe  <= 1'b0;
    end else if (prbs_on) begin
      fault_n_oe <= (prbs_cnt_reg != 8'h00);
    end else begin
      fault_n_oe <= (dec_cnt_reg > thresh_reg);
    end
  end

  // ==========================================================
  // channel gating, notify and pins
  logic        act_q_reg;
  logic [15:0] hold_reg;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      act_q_reg <= 1'b0;
      hold_reg  <= 16'h0000;
    end else begin
      act_q_reg <= serial_link_active;
      if (serial_link_active != act_q_reg) hold_reg <= 16'(HOLDOFF_CYCLES);
      else if (hold_reg != 16'h0000) hold_reg <= hold_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      back_channel_open         <= 1'b0;
      ahead_channel_open        <= 1'b0;
      notify_to_serializer      <= 1'b0;
      link_acquired             <= 1'b0;
      pseudo_random_test_enable <= 1'b0;
      pin0_out                  <= 1'b0;
      pin1_out                  <= 1'b0;
      pin0_oe                   <= 1'b0;
      pin1_oe                   <= 1'b0;
    end else begin
      // reverse channel needs no forward lock, only its enable bit and holdoff
      back_channel_open    <= link_ctrl_reg[BIT_BACK_EN] && hold_reg == 16'h0000 &&
                              serial_link_active == act_q_reg;
      ahead_channel_open   <= link_ctrl_reg[BIT_AHEAD_EN];
      notify_to_serializer <= sy_val_reg[SY_NOTIFY];
      link_acquired        <= video_lock;
      pseudo_random_test_enable <= prbs_on;
      pin0_oe              <= !pin_ctrl_reg[BIT_PIN0_DRV];
      pin1_oe              <= !pin_ctrl_reg[BIT_PIN1_DRV];
    end
  end

  // ==========================================================
  // checks
  AST_FAULT_THR: assert property (@(posedge clk_sys) disable iff (!rstn)
    !prbs_on ##1 (!prbs_on && dec_cnt_reg > thresh_reg) |=> fault_n_oe)
    else $error("fault pin not low above threshold");
  AST_FAULT_PRBS: assert property (@(posedge clk_sys) disable iff (!rstn)
    prbs_on && prbs_mismatch_hit && !rd_prbs |-> ##2 fault_n_oe)
    else $error("fault pin not low after mismatch");
  AST_READ_CLR: assert property (@(posedge clk_sys) disable iff (!rstn)
    rd_dec && !decode_fault_hit && !prbs_on |=> dec_cnt_reg == 8'h00
    ##1 (!fault_n_oe || prbs_on))
    else $error("read did not clear fault");
  AST_AUTO_TMR: assert property (@(posedge clk_sys) disable iff (!rstn)
    auto_tmr_reg < 8'(AUTO_CLR_CYC))
    else $error("auto clear timer overran");
  AST_AUTO_FIRE: assert property (@(posedge clk_sys) disable iff (!rstn)
    auto_fire && !decode_fault_hit |=> dec_cnt_reg == 8'h00)
    else $error("auto clear did not clear counter");
  AST_AUTO_OFF: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!auto_en || prbs_on) |-> !auto_fire)
    else $error("auto clear fired while off");
  AST_PRBS_CNT: assert property (@(posedge clk_sys) disable iff (!rstn)
    prbs_on && prbs_mismatch_hit && !rd_prbs && prbs_cnt_reg != CNT_MAX
    |=> prbs_cnt_reg == $past(prbs_cnt_reg) + 8'h01)
    else $error("mismatch not counted");
  AST_DEC_PRBS: assert property (@(posedge clk_sys) disable iff (!rstn)
    prbs_on |=> dec_cnt_reg == 8'h00)
    else $error("decode counted in self-test");
  AST_SAT: assert property (@(posedge clk_sys) disable iff (!rstn)
    dec_cnt_reg == CNT_MAX && !dec_clr && !prbs_on |=> dec_cnt_reg == CNT_MAX)
    else $error("decode counter wrapped");
  AST_HOLDOFF: assert property (@(posedge clk_sys) disable iff (!rstn)
    serial_link_active != act_q_reg |=> !back_channel_open [*8])
    else $error("reverse channel open during holdoff");
  AST_BACK_GATE: assert property (@(posedge clk_sys) disable iff (!rstn)
    !link_ctrl_reg[BIT_BACK_EN] |=> !back_channel_open)
    else $error("reverse channel open while disabled");
  AST_LOCK: assert property (@(posedge clk_sys) disable iff (!rstn)
    $fell(video_lock) |=> !link_acquired)
    else $error("link acquired without video lock");
  AST_PIN: assert property (@(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == ADDR_PIN_CTRL && !reg_wdata[BIT_PIN0_DRV] |-> ##2 pin0_oe)
    else $error("pin0 not driven low");
endmodule

// ==== src/let_pkg.sv ====
/*
  constants for the link error, self-test and pin housekeeping block.
  assumes one clock at the recovered link rate given below.
*/
package let_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_SER_ID    = 8'h00;
  localparam logic [7:0] ADDR_DES_ID    = 8'h01;
  localparam logic [7:0] ADDR_LINK_CTRL = 8'h04;
  localparam logic [7:0] ADDR_PIN_CTRL  = 8'h06;
  localparam logic [7:0] ADDR_THRESH    = 8'h0C;
  localparam logic [7:0] ADDR_DEC_CNT   = 8'h0D;
  localparam logic [7:0] ADDR_PRBS_CNT  = 8'h0E;
  // ==========================================================
  // field positions
  localparam int BIT_PRBS_EN  = 5;
  localparam int BIT_BACK_EN  = 1;
  localparam int BIT_AHEAD_EN = 0;
  localparam int BIT_AUTO_CLR = 6;
  localparam int BIT_PIN1_DRV = 3;
  localparam int BIT_PIN1_SNS = 2;
  localparam int BIT_PIN0_DRV = 1;
  localparam int BIT_PIN0_SNS = 0;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_LINK_CTRL = 8'h03;
  localparam logic [7:0] RST_PIN_CTRL  = 8'h0A;
  localparam logic [7:0] RST_THRESH    = 8'h00;
  localparam logic [7:0] CNT_MAX       = 8'hFF;
  localparam logic [1:0] SER_ID_MID    = 2'h0;
  localparam logic [1:0] DES_ID_MID    = 2'h1;
  // three-level strap codes
  localparam logic [1:0] STRAP_LOW     = 2'h0;
  localparam logic [1:0] STRAP_OPEN    = 2'h1;
  localparam logic [1:0] STRAP_HIGH    = 2'h2;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS  = 40;
  localparam int AUTO_CLR_NS    = 1000;
  localparam int AUTO_CLR_CYC   = (AUTO_CLR_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  AUTO_CLR_NS / CLK_PERIOD_NS;
  localparam int HOLDOFF_US     = 350;
  localparam int HOLDOFF_CYC    = (HOLDOFF_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BURST_LIMIT    = 16;
  localparam int BURST_WINDOW   = 256;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // ==========================================================
  // synchroniser lanes
  localparam int SY_NOTIFY = 0;
  localparam int SY_PIN0   = 1;
  localparam int SY_PIN1   = 2;
  localparam int SY_A_HI   = 3;
  localparam int SY_A_LO   = 4;
  localparam int SY_B_HI   = 5;
  localparam int SY_B_LO   = 6;
  localparam int SY_W      = 7;
endpackage

// ==== verification/let_far_side.sv ====
/*
  far side model: serializer test bit, link fault source, interrupt
  output fed by the reverse channel, pulled-up open-drain pins.
  assumes the bench moves its requests just after clk_sys rising edges.
*/
`timescale 1ns/1ps
module let_far_side (
  // serializer side and link faults
  input  wire logic ser_test_en,
  input  wire logic inject,
  input  wire logic des_test_en,
  output logic      decode_fault_hit,
  output logic      prbs_mismatch_hit,
  // reverse channel
  input  wire logic notify_to_serializer,
  output logic      ser_irq,
  // open-drain pins, external sinks
  input  wire logic pin0_oe,
  input  wire logic pin1_oe,
  input  wire logic ext0_low,
  input  wire logic ext1_low,
  output logic      pin0_in,
  output logic      pin1_in
);
  // ==========================================================
  // link faults
  // a bad link corrupts symbols whatever mode runs, so decode hits never stop
  assign decode_fault_hit  = inject;
  assign prbs_mismatch_hit = inject & ser_test_en & des_test_en;
  // ==========================================================
  // serializer interrupt follows forwarded level
  assign ser_irq = notify_to_serializer;
  // ==========================================================
  // pull-up wins unless someone sinks the wire
  assign pin0_in = ~(pin0_oe | ext0_low);
  assign pin1_in = ~(pin1_oe | ext1_low);
endmodule

// ==== verification/let_link_monitor_tb_top.sv ====
/*
  self-checking bench for the link monitor: register tasks, fault,
  self-test, channel, pin and strap sequences.
  assumes let_pkg, let_link_monitor and let_far_side are compiled first.
*/
`timescale 1ns/1ps
module let_link_monitor_tb_top;
  import let_pkg::*;
  // short holdoff keeps the run brief
  localparam int HOLD = 20;
  logic       clk_sys, rstn, reg_wr, reg_rd, relock_request, link_acquired;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       decode_fault_hit, prbs_mismatch_hit, video_lock, serial_link_active;
  logic       pseudo_random_test_enable, back_channel_open, ahead_channel_open;
  logic       notify_to_serializer, remote_notify_in, fault_n_out, fault_n_oe;
  logic       pin0_in, pin0_out, pin0_oe, pin1_in, pin1_out, pin1_oe, ser_irq;
  logic       device_id_strap_a_hi, device_id_strap_a_lo;
  logic       device_id_strap_b_hi, device_id_strap_b_lo;
  logic       inject, ser_test_en, ext0_low, ext1_low, relock_seen;
  int         fail_count, total_checks, n;

  let_link_monitor #(.HOLDOFF_CYCLES(HOLD)) DUT (.clk_sys, .rstn, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .decode_fault_hit, .prbs_mismatch_hit, .video_lock,
    .serial_link_active, .relock_request, .link_acquired, .pseudo_random_test_enable,
    .back_channel_open, .ahead_channel_open, .notify_to_serializer, .remote_notify_in,
    .fault_n_out, .fault_n_oe, .pin0_in, .pin0_out, .pin0_oe, .pin1_in, .pin1_out,
    .pin1_oe, .device_id_strap_a_hi, .device_id_strap_a_lo, .device_id_strap_b_hi,
    .device_id_strap_b_lo);
  let_far_side FAR (.ser_test_en, .inject, .des_test_en(pseudo_random_test_enable),
    .decode_fault_hit, .prbs_mismatch_hit, .notify_to_serializer, .ser_irq, .pin0_oe,
    .pin1_oe, .ext0_low, .ext1_low, .pin0_in, .pin1_in);

  // ==========================================================
  // clock and pulse catcher
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // relock is a one-cycle pulse, so latch it rather than poll
  always @(posedge clk_sys) begin
    if (relock_request === 1'b1) relock_seen <= 1'b1;
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    cyc(1);
    chk(reg_rdata, exp);
  endtask
  task automatic faults(input int k, input int gap);
    for (int i = 0; i < k; i++) begin
      @(posedge clk_sys);
      inject <= 1'b1;
      @(posedge clk_sys);
      inject <= 1'b0;
      repeat (gap) @(posedge clk_sys);
    end
    #1;
  endtask
  // bounded wait; m holds the edges spent
  task automatic wsig(input int s, input logic v, input int lim, output int m);
    logic x;
    for (m = 0; m < lim; m++) begin
      x = (s == 0) ? fault_n_oe : (s == 1) ? back_channel_open : ser_irq;
      if (x === v) return;
      @(posedge clk_sys);
      #1;
    end
    fail_count++;
    $display("[FAIL] %0t ns: wait ran out", $time);
    results();
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    cyc(6);
  endtask

  // ==========================================================
  // sequence
  initial begin
    {rstn, reg_wr, reg_rd, inject, ser_test_en, ext0_low, ext1_low} = '0;
    {reg_addr, reg_wdata, video_lock, remote_notify_in, relock_seen} = '0;
    serial_link_active = 1'b1;
    {device_id_strap_a_hi, device_id_strap_a_lo} = 2'b10;
    {device_id_strap_b_hi, device_id_strap_b_lo} = 2'b01;
    fail_count = 0;
    total_checks = 0;
    do_reset();
    rd(ADDR_SER_ID, 8'h80);
    rd(ADDR_DES_ID, 8'h90);
    rd(ADDR_LINK_CTRL, 8'h03);
    rd(ADDR_PIN_CTRL, 8'h0F);
    rd(8'h02, 8'h00);
    chk({5'h00, fault_n_out, pin0_out, pin1_out}, 8'h00);
    @(posedge clk_sys) remote_notify_in <= 1'b1;
    wsig(2, 1'b1, 10, n);
    @(posedge clk_sys) remote_notify_in <= 1'b0;
    wsig(2, 1'b0, 10, n);
    @(posedge clk_sys) {device_id_strap_a_hi, device_id_strap_b_lo} <= 2'b00;
    do_reset();
    rd(ADDR_SER_ID, 8'h44);
    rd(ADDR_DES_ID, 8'h54);
    wr(ADDR_SER_ID, 8'h57);
    rd(ADDR_SER_ID, 8'h56);
    $display("test resets done");
    wr(ADDR_PIN_CTRL, 8'h08);
    cyc(8);
    chk({6'h00, pin1_oe, pin0_oe}, 8'h01);
    rd(ADDR_PIN_CTRL, 8'h0C);
    @(posedge clk_sys) ext1_low <= 1'b1;
    cyc(8);
    rd(ADDR_PIN_CTRL, 8'h08);
    @(posedge clk_sys) ext1_low <= 1'b0;
    wr(ADDR_PIN_CTRL, 8'h0A);
    $display("test pins done");
    wr(ADDR_THRESH, 8'h02);
    rd(ADDR_THRESH, 8'h02);
    faults(2, 0);
    cyc(3);
    chk(8'(fault_n_oe), 8'h00);
    faults(1, 0);
    cyc(40);
    chk(8'(fault_n_oe), 8'h01);
    wr(ADDR_DEC_CNT, 8'h55);
    rd(ADDR_DEC_CNT, 8'h03);
    cyc(2);
    chk(8'(fault_n_oe), 8'h00);
    faults(260, 20);
    rd(ADDR_DEC_CNT, 8'hFF);
    faults(40, 0);
    cyc(4);
    chk(8'(relock_seen), 8'h01);
    @(posedge clk_sys) video_lock <= 1'b1;
    cyc(4);
    chk({6'h00, link_acquired, fault_n_oe}, 8'h02);
    rd(ADDR_DEC_CNT, 8'h00);
    $display("test decode faults done");
    wr(ADDR_PIN_CTRL, 8'h4A);
    faults(3, 0);
    wsig(0, 1'b1, 10, n);
    wsig(0, 1'b0, 40, n);
    chk(8'(n), 8'd26);
    $display("test auto clear done");
    @(posedge clk_sys) ser_test_en <= 1'b1;
    wr(ADDR_LINK_CTRL, 8'h23);
    cyc(2);
    chk(8'(pseudo_random_test_enable), 8'h01);
    faults(1, 0);
    cyc(2);
    chk(8'(fault_n_oe), 8'h01);
    cyc(60);
    chk(8'(fault_n_oe), 8'h01);
    rd(ADDR_DEC_CNT, 8'h00);
    rd(ADDR_PRBS_CNT, 8'h01);
    cyc(2);
    chk(8'(fault_n_oe), 8'h00);
    faults(3, 1);
    rd(ADDR_PRBS_CNT, 8'h03);
    wr(ADDR_LINK_CTRL, 8'h03);
    @(posedge clk_sys) ser_test_en <= 1'b0;
    $display("test self-test done");
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_LINK_CTRL, 8'(c));
      cyc(2);
      chk({6'h00, back_channel_open, ahead_channel_open}, 8'(c));
    end
    @(posedge clk_sys) video_lock <= 1'b0;
    cyc(2);
    chk(8'(link_acquired), 8'h00);
    @(posedge clk_sys) serial_link_active <= 1'b0;
    wsig(1, 1'b0, 5, n);
    wsig(1, 1'b1, 40, n);
    chk(8'(n), 8'(HOLD + 1));
    $display("test channels done");
    results();
  end
endmodule
